//--- verilog/clock_switch.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
// system clock source selection, switching sequencer and trim
module clock_switch
#(
    parameter int STABLE_CYCLES = clk_switch_pkg::STABLE_CYC
)
(
    input  wire logic       sys_clk_in,     // 20 MHz system clock
    input  wire logic       rst_in,         // sync reset, high
    input  wire logic [7:0] addr_in,        // register address
    input  wire logic [7:0] wdata_in,       // write data
    input  wire logic       wr_in,          // write strobe
    input  wire logic       rd_in,          // read strobe
    output logic      [7:0] rdata_out,      // read data, next cycle
    input  wire logic [2:0] primary_mode_in, // primary mode config
    input  wire logic       two_speed_en_in, // two-speed start-up
    input  wire logic       failsafe_monitor_enable_in, // fail-safe
    input  wire logic       wake_in,        // wake from sleep pulse
    input  wire logic       prim_fail_in,   // primary osc failed
    input  wire logic       sec_fail_in,    // secondary osc failed
    input  wire logic       prim_fall_in,   // primary falling edge
    input  wire logic       sec_fall_in,    // secondary falling edge
    input  wire logic       int_fall_in,    // internal block fall
    input  wire logic       slow_fall_in,   // slow internal fall
    output logic      [1:0] sys_source_out, // active source
    output logic            clock_output_hold_out, // clock held low
    output logic      [2:0] int_freq_out,   // internal freq code
    output logic      [5:0] freq_trim_out,  // signed trim offset
    output logic            watchdog_suspend_out, // counter borrowed
    output logic            watchdog_clear_out,   // clear pulse
    output logic            cpu_hold_out    // execution waits
);
    clk_switch_pkg::sw_state_t state_q;
    clk_switch_pkg::sw_state_t state_d;
    clk_switch_pkg::src_t      active_q;
    clk_switch_pkg::src_t      active_d;
    clk_switch_pkg::src_t      target_q;
    clk_switch_pkg::src_t      target_d;
    clk_switch_pkg::src_t      sel_src;

    logic [1:0]  sel_q;
    logic [2:0]  ifs_q;
    logic [5:0]  trim_q;
    logic        run_flag_q;
    logic        stable_q;
    logic        pending_q;
    logic        cpu_hold_q;
    logic        wd_clr_q;
    logic [7:0]  rdata_q;
    logic [16:0] stab_cnt_q;
    logic        stab_run_q;

    logic        crystal;
    logic        ctrl_wr;
    logic [1:0]  sel_new;
    logic [2:0]  ifs_new;
    logic        change;
    logic        take;
    logic        stab_start;
    logic        stab_done;
    logic        cur_fall;
    logic        req_fall;
    logic        cnt_start;
    logic [10:0] cnt_limit;
    logic        cnt_tick;
    logic        cnt_done;
    logic        fail_now;
    logic        wake_now;

    // falling edge strobe of a given source
    function automatic logic fall_of(input clk_switch_pkg::src_t s,
                                     input logic [3:0] falls);
        unique case (s)
            clk_switch_pkg::SRC_PRIMARY:  fall_of = falls[0];
            clk_switch_pkg::SRC_SECOND:   fall_of = falls[1];
            clk_switch_pkg::SRC_INTERNAL: fall_of = falls[2];
            clk_switch_pkg::SRC_SLOW:     fall_of = falls[3];
        endcase
    endfunction

    assign crystal = (primary_mode_in == clk_switch_pkg::MODE_LP)
                  || (primary_mode_in == clk_switch_pkg::MODE_XT)
                  || (primary_mode_in == clk_switch_pkg::MODE_HS);

    // decode of software writes to the control register
    assign ctrl_wr = wr_in && (addr_in == clk_switch_pkg::CTRL_ADDR);
    assign ifs_new = wdata_in[clk_switch_pkg::IFS_LSB +: 3];
    assign sel_new = (wdata_in[clk_switch_pkg::SEL_LSB +: 2]
                      == clk_switch_pkg::SEL_RESERVED)
                   ? sel_q : wdata_in[clk_switch_pkg::SEL_LSB +: 2];
    assign change  = ctrl_wr && ((sel_new != sel_q) || (ifs_new != ifs_q));
    // leaving the slow code starts the delay
    assign stab_start = ctrl_wr && (ifs_q == clk_switch_pkg::IFS_SLOW)
                     && (ifs_new != clk_switch_pkg::IFS_SLOW);
    assign stab_done  = stab_run_q
                     && (stab_cnt_q == 17'(STABLE_CYCLES - 1));

    always_comb
    begin
        unique case (sel_q)
            clk_switch_pkg::SEL_SECOND:   sel_src = clk_switch_pkg::SRC_SECOND;
            clk_switch_pkg::SEL_INTERNAL:
                sel_src = clk_switch_pkg::SRC_INTERNAL;
            default:                      sel_src = clk_switch_pkg::SRC_PRIMARY;
        endcase
    end

    assign cur_fall = fall_of(active_q, {slow_fall_in, int_fall_in,
                                         sec_fall_in, prim_fall_in});
    assign req_fall = fall_of(target_q, {slow_fall_in, int_fall_in,
                                         sec_fall_in, prim_fall_in});

    // only the clock now running can fail over
    assign fail_now = failsafe_monitor_enable_in
        && (((active_q == clk_switch_pkg::SRC_PRIMARY) && prim_fail_in)
         || ((active_q == clk_switch_pkg::SRC_SECOND) && sec_fail_in));
    // wake with two-speed, crystal and primary select
    assign wake_now = wake_in && two_speed_en_in && crystal
                   && (sel_q == clk_switch_pkg::SEL_PRIMARY);

    // switching sequencer; a failed clock gives no edges, so
    // fail-over skips alignment and moves at once
    always_comb
    begin
        state_d  = state_q;
        active_d = active_q;
        target_d = target_q;
        take     = 1'b0;
        unique case (state_q)
            clk_switch_pkg::ST_BOOT:
            begin
                target_d = clk_switch_pkg::SRC_PRIMARY;
                if (crystal && two_speed_en_in)
                begin
                    active_d = clk_switch_pkg::SRC_SLOW;
                    state_d  = clk_switch_pkg::ST_OST;
                end
                else if (crystal)
                begin
                    active_d = clk_switch_pkg::SRC_PRIMARY;
                    state_d  = clk_switch_pkg::ST_OST;
                end
                else
                begin
                    active_d = clk_switch_pkg::SRC_PRIMARY;
                    state_d  = clk_switch_pkg::ST_RUN;
                end
            end
            clk_switch_pkg::ST_RUN:
            begin
                if (fail_now)
                begin
                    active_d = clk_switch_pkg::SRC_SLOW;
                end
                else if (wake_now)
                begin
                    active_d = clk_switch_pkg::SRC_SLOW;
                    target_d = clk_switch_pkg::SRC_PRIMARY;
                    state_d  = clk_switch_pkg::ST_OST;
                end
                // switch starts after the write cycle
                else if (pending_q)
                begin
                    take     = 1'b1;
                    target_d = sel_src;
                    if ((sel_src == clk_switch_pkg::SRC_PRIMARY) && crystal
                        && (active_q != clk_switch_pkg::SRC_PRIMARY))
                    begin
                        state_d = clk_switch_pkg::ST_OST;
                    end
                    else
                    begin
                        state_d = clk_switch_pkg::ST_ALIGN;
                    end
                end
            end
            clk_switch_pkg::ST_OST:
            begin
                if (cnt_done)
                begin
                    state_d = (active_q == target_q)
                            ? clk_switch_pkg::ST_RUN
                            : clk_switch_pkg::ST_ALIGN;
                end
            end
            clk_switch_pkg::ST_ALIGN:
            begin
                // wait a fall of current clock
                if (cur_fall)
                begin
                    state_d = clk_switch_pkg::ST_HOLD;
                end
            end
            clk_switch_pkg::ST_HOLD:
            begin
                if (cnt_done)
                begin
                    active_d = target_q;
                    state_d  = clk_switch_pkg::ST_RUN;
                end
            end
        endcase
    end

    // one counter serves both the start-up and the hold count
    assign cnt_start = (state_d != state_q)
                    && ((state_d == clk_switch_pkg::ST_OST)
                     || (state_d == clk_switch_pkg::ST_HOLD));
    assign cnt_limit = (state_q == clk_switch_pkg::ST_HOLD)
                     ? clk_switch_pkg::HOLD_TICKS
                     : clk_switch_pkg::OST_TICKS;
    assign cnt_tick  = (state_q == clk_switch_pkg::ST_HOLD)
                     ? req_fall : prim_fall_in;

    fall_counter u_fall_counter
    (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .start_in   (cnt_start),
        .limit_in   (cnt_limit),
        .tick_in    (cnt_tick),
        .done_out   (cnt_done)
    );

    // sequencer state
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            state_q  <= clk_switch_pkg::ST_BOOT;
            active_q <= clk_switch_pkg::SRC_PRIMARY;
            target_q <= clk_switch_pkg::SRC_PRIMARY;
        end
        else
        begin
            state_q  <= state_d;
            active_q <= active_d;
            target_q <= target_d;
        end
    end

    // software fields; writes are accepted during a switch
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            sel_q  <= clk_switch_pkg::SEL_RST;
            ifs_q  <= clk_switch_pkg::IFS_RST;
            trim_q <= clk_switch_pkg::TRIM_RST;
        end
        else
        begin
            if (ctrl_wr)
            begin
                sel_q <= sel_new;
                ifs_q <= ifs_new;
            end
            if (wr_in && (addr_in == clk_switch_pkg::TRIM_ADDR))
            begin
                trim_q <= wdata_in[5:0];
            end
        end
    end

    // a change during a switch queues a further one; set wins
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            pending_q <= 1'b0;
        end
        else
        begin
            pending_q <= change || (pending_q && !take);
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            stab_cnt_q <= 17'h00000;
            stab_run_q <= 1'b0;
        end
        else if (stab_start)
        begin
            stab_cnt_q <= 17'h00000;
            stab_run_q <= 1'b1;
        end
        else if (stab_done)
        begin
            stab_run_q <= 1'b0;
        end
        else if (stab_run_q)
        begin
            stab_cnt_q <= stab_cnt_q + 17'h00001;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            stable_q <= 1'b0;
        end
        else if (stab_done)
        begin
            stable_q <= 1'b1;
        end
        else if (stab_start)
        begin
            stable_q <= 1'b0;
        end
    end

    // running flag follows primary after count
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            run_flag_q <= 1'b0;
        end
        else
        begin
            run_flag_q <= (state_q == clk_switch_pkg::ST_RUN)
                       && (active_q == clk_switch_pkg::SRC_PRIMARY);
        end
    end

    // without two-speed, execution waits for the crystal
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            cpu_hold_q <= 1'b1;
        end
        else
        begin
            cpu_hold_q <= (state_d == clk_switch_pkg::ST_BOOT)
                || ((state_d == clk_switch_pkg::ST_OST)
                 && (active_d == clk_switch_pkg::SRC_PRIMARY));
        end
    end

    // watchdog cleared as the switch completes
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            wd_clr_q <= 1'b0;
        end
        else
        begin
            wd_clr_q <= (state_q != clk_switch_pkg::ST_RUN)
                     && (state_q != clk_switch_pkg::ST_BOOT)
                     && (state_d == clk_switch_pkg::ST_RUN);
        end
    end

    // register reads; unmapped addresses read zero
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            rdata_q <= 8'h00;
        end
        else if (rd_in && (addr_in == clk_switch_pkg::CTRL_ADDR))
        begin
            rdata_q <= {1'b0, ifs_q, run_flag_q, stable_q, sel_q};
        end
        else if (rd_in && (addr_in == clk_switch_pkg::TRIM_ADDR))
        begin
            rdata_q <= {2'h0, trim_q};
        end
        else
        begin
            rdata_q <= 8'h00;
        end
    end

    // outputs; trim drives the oscillators with no done flag
    assign rdata_out             = rdata_q;
    assign sys_source_out        = active_q;
    // clock output held low during the hold count
    assign clock_output_hold_out = (state_q == clk_switch_pkg::ST_HOLD);
    assign int_freq_out          = ifs_q;
    assign freq_trim_out         = trim_q;
    // watchdog counter borrowed as start-up timer
    assign watchdog_suspend_out  = (state_q != clk_switch_pkg::ST_RUN);
    assign watchdog_clear_out    = wd_clr_q;
    assign cpu_hold_out          = cpu_hold_q;
endmodule

//--- verilog/clk_switch_pkg.sv
package clk_switch_pkg;
    // register offsets
    localparam logic [7:0] CTRL_ADDR    = 8'h8F;
    localparam logic [7:0] TRIM_ADDR    = 8'h90;
    // control field positions
    localparam int         SEL_LSB      = 0;
    localparam int         STABLE_BIT   = 2;
    localparam int         RUN_BIT      = 3;
    localparam int         IFS_LSB      = 4;
    // reset values
    localparam logic [1:0] SEL_RST      = 2'h0;
    localparam logic [2:0] IFS_RST      = 3'h0;
    localparam logic [5:0] TRIM_RST     = 6'h00;
    // source select codes; 11 is reserved
    localparam logic [1:0] SEL_PRIMARY  = 2'h0;
    localparam logic [1:0] SEL_SECOND   = 2'h1;
    localparam logic [1:0] SEL_INTERNAL = 2'h2;
    localparam logic [1:0] SEL_RESERVED = 2'h3;
    // frequency codes: 000 31.25k, 001 125k .. 110 4M, 111 8M
    localparam logic [2:0] IFS_SLOW     = 3'h0;
    // trim extremes, two's complement
    localparam logic [5:0] TRIM_MAX     = 6'h1F;
    localparam logic [5:0] TRIM_MIN     = 6'h20;
    // crystal primary mode codes on the mode pins
    localparam logic [2:0] MODE_LP      = 3'h0;
    localparam logic [2:0] MODE_XT      = 3'h1;
    localparam logic [2:0] MODE_HS      = 3'h2;
    // timing
    localparam int         CLK_HZ       = 20_000_000;
    localparam int         STABLE_US    = 4000;
    localparam int         STABLE_CYC   = STABLE_US * (CLK_HZ / 1_000_000);
    localparam int         TRIM_FAST_US = 1000;
    localparam int         TRIM_SLOW_TK = 8;
    localparam logic [10:0] OST_TICKS   = 11'h400;
    localparam logic [10:0] HOLD_TICKS  = 11'h008;

    // active system clock source
    typedef enum logic [1:0] {
        SRC_PRIMARY  = 2'h0,
        SRC_SECOND   = 2'h1,
        SRC_INTERNAL = 2'h2,
        SRC_SLOW     = 2'h3
    } src_t;

    typedef enum logic [4:0] {
        ST_BOOT  = 5'b00001,
        ST_RUN   = 5'b00010,
        ST_OST   = 5'b00100,
        ST_ALIGN = 5'b01000,
        ST_HOLD  = 5'b10000
    } sw_state_t;
endpackage

//--- verilog/fall_counter.sv
`timescale 1ns/1ps
// counts falling-edge strobes of a clock until a limit is reached
module fall_counter
(
    input  wire logic        sys_clk_in, // system clock
    input  wire logic        rst_in,     // sync reset, high
    input  wire logic        start_in,   // restart the count
    input  wire logic [10:0] limit_in,   // falls to count
    input  wire logic        tick_in,    // one falling edge seen
    output logic             done_out    // pulse on last fall
);
    logic [10:0] count_q;
    logic        busy_q;
    logic        last;

    assign last = busy_q && tick_in && (count_q == limit_in - 11'h001);

    // count runs only between start and the final fall
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in || start_in)
        begin
            count_q <= 11'h000;
            busy_q  <= !rst_in;
        end
        else if (last)
        begin
            busy_q <= 1'b0;
        end
        else if (busy_q && tick_in)
        begin
            count_q <= count_q + 11'h001;
        end
    end

    // done is registered so the switch lands on a clean edge
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            done_out <= 1'b0;
        end
        else
        begin
            done_out <= last && !start_in;
        end
    end
endmodule

//--- bench/clock_switch_checker.sv
`timescale 1ns/1ps
// port-level checks for the clock switch; sees only top-level ports
module clock_switch_checker
#(
    parameter int STABLE_CYCLES = 20
)
(
    input wire logic       sys_clk_in,            // system clock
    input wire logic       rst_in,                // sync reset, high
    input wire logic [7:0] addr_in,               // register address
    input wire logic [7:0] wdata_in,              // write data
    input wire logic       wr_in,                 // write strobe
    input wire logic       rd_in,                 // read strobe
    input wire logic [7:0] rdata_out,             // read data
    input wire logic       failsafe_monitor_enable_in, // fail-safe
    input wire logic       prim_fail_in,          // primary failed
    input wire logic       sec_fail_in,           // secondary failed
    input wire logic [1:0] sys_source_out,        // active source
    input wire logic       clock_output_hold_out, // clock held low
    input wire logic [2:0] int_freq_out,          // freq code
    input wire logic [5:0] freq_trim_out,         // trim offset
    input wire logic       watchdog_suspend_out,  // counter borrowed
    input wire logic       watchdog_clear_out     // clear pulse
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    // reset itself must not be masked by the reset
    a_reset_primary: assert property (disable iff (1'b0)
        rst_in |=> sys_source_out == 2'h0 && rdata_out == 8'h00)
        else $error("select not primary after reset");
    a_trim_upper_zero: assert property (
        rd_in && addr_in == clk_switch_pkg::TRIM_ADDR
        |=> rdata_out[7:6] == 2'h0)
        else $error("trim upper bits read nonzero");
    a_trim_offset: assert property (
        wr_in && addr_in == clk_switch_pkg::TRIM_ADDR
        |=> freq_trim_out == $past(wdata_in[5:0]))
        else $error("trim output differs from written code");
    a_freq_immediate: assert property (
        wr_in && addr_in == clk_switch_pkg::CTRL_ADDR
        |=> int_freq_out == $past(wdata_in[6:4]))
        else $error("frequency code not taken at once");
    // fail-over acts only while the sequencer is idle
    a_failover_slow: assert property (
        failsafe_monitor_enable_in && !watchdog_suspend_out &&
        ((sys_source_out == 2'h0 && prim_fail_in) ||
         (sys_source_out == 2'h1 && sec_fail_in)) |=> sys_source_out == 2'h3)
        else $error("failed clock not replaced by slow clock");
    a_hold_suspends: assert property (
        clock_output_hold_out |-> watchdog_suspend_out)
        else $error("watchdog live during hold");
    a_clear_in_run: assert property (
        watchdog_clear_out |-> !watchdog_suspend_out && !clock_output_hold_out)
        else $error("watchdog clear outside run");
    a_hold_source_steady: assert property (
        clock_output_hold_out |-> $stable(sys_source_out))
        else $error("source changed while clock held");
endmodule

bind clock_switch clock_switch_checker #(.STABLE_CYCLES(STABLE_CYCLES))
    clock_switch_checker_inst (.sys_clk_in, .rst_in, .addr_in, .wdata_in,
    .wr_in, .rd_in, .rdata_out, .failsafe_monitor_enable_in, .prim_fail_in,
    .sec_fail_in, .sys_source_out, .clock_output_hold_out, .int_freq_out,
    .freq_trim_out, .watchdog_suspend_out, .watchdog_clear_out);

//--- bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic       sys_clk_in, rst_in, wr_in, rd_in, two_speed, fsm, wake;
    logic       prim_fail, falls, hold, susp, wclr, cpu_hold, sec_fail;
    logic [7:0] addr_in, wdata_in, rdata_out, rv;
    logic [2:0] mode, ifreq;
    logic [1:0] src, fdiv;
    logic [5:0] trim;
    int         err_total, n_compared;

    clock_switch #(.STABLE_CYCLES(20)) clock_switch_inst (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .primary_mode_in(mode),
        .two_speed_en_in(two_speed), .failsafe_monitor_enable_in(fsm),
        .wake_in(wake), .prim_fail_in(prim_fail), .sec_fail_in(sec_fail),
        .prim_fall_in(falls), .sec_fall_in(falls), .int_fall_in(falls),
        .slow_fall_in(falls), .sys_source_out(src),
        .clock_output_hold_out(hold), .int_freq_out(ifreq),
        .freq_trim_out(trim), .watchdog_suspend_out(susp),
        .watchdog_clear_out(wclr), .cpu_hold_out(cpu_hold));

    // 50 ns period
    initial
    begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end

    // one falling edge of every oscillator each fourth cycle
    always @(posedge sys_clk_in)
    begin
        fdiv  <= rst_in ? 2'h0 : fdiv + 2'h1;
        falls <= (fdiv == 2'h0) && !rst_in;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge sys_clk_in);
        wr_in    <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge sys_clk_in);
        rd_in   <= 1'b0;
        #1 d = rdata_out;
    endtask

    task automatic do_reset();
        @(posedge sys_clk_in);
        rst_in <= 1'b1;
        repeat (20) @(posedge sys_clk_in);
        rst_in <= 1'b0;
    endtask

    // bounded wait for the sequencer to return to run
    task automatic wait_run(output logic saw_hold, output logic saw_clr);
        int i;
        saw_hold = 1'b0;
        saw_clr  = 1'b0;
        repeat (2) @(posedge sys_clk_in);
        for (i = 0; i < 6000; i++)
        begin
            @(posedge sys_clk_in);
            #1;
            if (hold === 1'b1) saw_hold = 1'b1;
            if (wclr === 1'b1) saw_clr = 1'b1;
            if (susp === 1'b0) break;
        end
        if (i == 6000)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, 1, 0);
            tally_and_finish();
        end
    endtask

    task automatic s_reset_trim();
        logic h, c;
        wait_run(h, c);
        chk({7'h00, cpu_hold}, 8'h00);
        bus_rd(8'h8F, rv);
        chk(rv & 8'hF3, 8'h00);
        bus_rd(8'h90, rv);
        chk(rv, 8'h00);
        bus_wr(8'h90, 8'hE0);
        bus_rd(8'h90, rv);
        chk(rv, 8'h20);
        chk({2'h0, trim}, 8'h20);
        bus_wr(8'h90, 8'h1F);
        bus_wr(8'h91, 8'hFF);
        bus_rd(8'h91, rv);
        chk(rv, 8'h00);
        bus_rd(8'h90, rv);
        chk(rv, 8'h1F);
    endtask

    // slow code to fastest on the internal block, then between fast codes
    task automatic s_internal();
        logic h, c;
        bus_wr(8'h8F, 8'h72);
        bus_rd(8'h8F, rv);
        chk(rv & 8'h04, 8'h00);
        wait_run(h, c);
        chk({6'h00, src}, 8'h02);
        chk({5'h00, ifreq}, 8'h07);
        chk({6'h00, h, c}, 8'h03);
        repeat (25) @(posedge sys_clk_in);
        bus_rd(8'h8F, rv);
        chk(rv, 8'h76);
        bus_wr(8'h8F, 8'h52);
        bus_rd(8'h8F, rv);
        chk(rv, 8'h56);
        wait_run(h, c);
        chk({7'h00, h}, 8'h01);
        bus_wr(8'h8F, 8'h53);
        bus_rd(8'h8F, rv);
        chk(rv, 8'h56);
    endtask

    task automatic s_primary_failover();
        logic h, c;
        bus_wr(8'h8F, 8'h50);
        wait_run(h, c);
        chk({6'h00, src}, 8'h00);
        repeat (2) @(posedge sys_clk_in);
        bus_rd(8'h8F, rv);
        chk(rv, 8'h5C);
        @(posedge sys_clk_in);
        fsm       <= 1'b1;
        prim_fail <= 1'b1;
        @(posedge sys_clk_in);
        prim_fail <= 1'b0;
        fsm       <= 1'b0;
        #1 chk({6'h00, src}, 8'h03);
    endtask

    // crystal without two-speed: execution waits for the start-up count
    task automatic s_crystal_wait();
        logic h, c;
        @(posedge sys_clk_in);
        mode <= 3'h1;
        do_reset();
        repeat (3) @(posedge sys_clk_in);
        #1 chk({4'h0, src, cpu_hold, hold}, 8'h02);
        wait_run(h, c);
        chk({6'h00, cpu_hold, h}, 8'h00);
    endtask

    // wake from sleep with two-speed crystal: slow, then primary
    task automatic s_wake();
        logic h, c;
        @(posedge sys_clk_in);
        wake <= 1'b1;
        @(posedge sys_clk_in);
        wake <= 1'b0;
        #1 chk({6'h00, src}, 8'h03);
        wait_run(h, c);
        chk({4'h0, src, h, c}, 8'h03);
    endtask

    // secondary source, then its failure drops to the slow clock
    task automatic s_second_failover();
        logic h, c;
        bus_wr(8'h8F, 8'h51);
        wait_run(h, c);
        chk({6'h00, src}, 8'h01);
        @(posedge sys_clk_in);
        fsm      <= 1'b1;
        sec_fail <= 1'b1;
        @(posedge sys_clk_in);
        sec_fail <= 1'b0;
        fsm      <= 1'b0;
        #1 chk({6'h00, src}, 8'h03);
    endtask

    // crystal with two-speed: slow clock first, then primary
    task automatic s_two_speed();
        logic h, c;
        @(posedge sys_clk_in);
        mode      <= 3'h1;
        two_speed <= 1'b1;
        do_reset();
        repeat (3) @(posedge sys_clk_in);
        #1 chk({6'h00, src}, 8'h03);
        chk({7'h00, cpu_hold}, 8'h00);
        bus_rd(8'h8F, rv);
        chk(rv & 8'h0B, 8'h00);
        wait_run(h, c);
        chk({6'h00, src}, 8'h00);
        chk({7'h00, h}, 8'h01);
        repeat (2) @(posedge sys_clk_in);
        bus_rd(8'h8F, rv);
        chk(rv & 8'h0B, 8'h08);
    endtask

    initial
    begin
        err_total  = 0;
        n_compared = 0;
        rst_in = 1'b1;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 8'h00;
        wdata_in = 8'h00;
        mode = 3'h4;
        two_speed = 1'b0;
        fsm = 1'b0;
        prim_fail = 1'b0;
        sec_fail = 1'b0;
        wake = 1'b0;
        do_reset();
        s_reset_trim();
        s_internal();
        s_primary_failover();
        s_crystal_wait();
        s_two_speed();
        s_wake();
        s_second_failover();
        tally_and_finish();
    end
endmodule
